// ---- hw/fsa_fault_aggregator.sv ----
// fault signal aggregator: masks, foldback status and fault output
`timescale 1ns/1ns

module fsa_fault_aggregator (
    input  wire logic        mclk,                        // core clock
    input  wire logic        reset_n,                     // sync reset
    // register port
    input  wire logic [7:0]  reg_addr,                    // register offset
    input  wire logic [7:0]  reg_wdata,                   // write data
    input  wire logic        reg_wr,                      // write strobe
    input  wire logic        reg_rd,                      // read strobe
    output logic      [7:0]  reg_rdata,                   // read data
    output logic             reg_rvalid,                  // read data valid
    // per-channel protection state
    input  wire logic [11:0] chan_state,                  // 3 bits per ch
    input  wire logic        invalid_clock_latched,       // stored flag
    input  wire logic        invalid_clock_live,          // present flag
    input  wire logic [4:0]  overheat_shutdown_latched,   // ch1..4, global
    input  wire logic [4:0]  overheat_shutdown_live,      // ch1..4, global
    // supply flags
    input  wire logic [1:0]  battery_undervoltage,        // {live, stored}
    input  wire logic [1:0]  battery_overvoltage,         // {live, stored}
    input  wire logic [1:0]  stage_supply_undervoltage,   // {live, stored}
    input  wire logic [1:0]  stage_supply_overvoltage,    // {live, stored}
    input  wire logic [1:0]  gate_supply_fault,           // {live, stored}
    input  wire logic        logic_supply_reset_latched,  // stored only
    // per-channel stored faults
    input  wire logic [3:0]  dc_offset_latched,           // per channel
    input  wire logic [3:0]  overcurrent_latched,         // per channel
    input  wire logic [3:0]  current_limit_latched,       // per channel
    input  wire logic [3:0]  load_diag_done,              // per channel
    input  wire logic [4:0]  overtemp_warn_latched,       // ch1..4, global
    input  wire logic        warn_other,                  // other warnings
    input  wire logic [4:0]  foldback_attenuation,        // gain code
    // outputs
    output logic             warn_active,                 // warning signal
    output logic             fault_active                 // fault signal
);

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    logic [7:0] mask_latched_reg;
    logic [7:0] mask_live_reg;
    logic [7:0] warn_conf_reg;
    logic [4:0] foldback_reg;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            mask_latched_reg <= fsa_pkg::RST_MASK_LATCHED;
        end else if (reg_wr && reg_addr == fsa_pkg::ADDR_MASK_LATCHED) begin
            mask_latched_reg <= reg_wdata;
        end
    end

    // reserved bits are stored so they read back, but steer nothing
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            mask_live_reg <= fsa_pkg::RST_MASK_LIVE;
        end else if (reg_wr && reg_addr == fsa_pkg::ADDR_MASK_LIVE) begin
            mask_live_reg <= reg_wdata;
        end
    end

    // only the overtemp warning enable lives here; the other warning
    // enables belong to the warning logic, which feeds warn_other
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            warn_conf_reg <= fsa_pkg::RST_WARN_CONF;
        end else if (reg_wr && reg_addr == fsa_pkg::ADDR_WARN_CONF) begin
            warn_conf_reg <= reg_wdata & fsa_pkg::RST_WARN_CONF;
        end
    end

    // ------------------------------------------------------------------
    // foldback status
    // ------------------------------------------------------------------
    // codes above the last step are clipped to -12 dB
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            foldback_reg <= fsa_pkg::RST_ZERO[4:0];
        end else if (foldback_attenuation > fsa_pkg::GAIN_MAX_CODE) begin
            foldback_reg <= fsa_pkg::GAIN_MAX_CODE;
        end else begin
            foldback_reg <= foldback_attenuation;
        end
    end

    // ------------------------------------------------------------------
    // register read
    // ------------------------------------------------------------------
    logic [7:0] read_mux;

    always_comb begin
        case (reg_addr)
            fsa_pkg::ADDR_FOLDBACK_STAT: read_mux = {3'h0, foldback_reg};
            fsa_pkg::ADDR_MASK_LATCHED:  read_mux = mask_latched_reg;
            fsa_pkg::ADDR_MASK_LIVE:     read_mux = mask_live_reg;
            fsa_pkg::ADDR_WARN_CONF:     read_mux = warn_conf_reg;
            default:                     read_mux = fsa_pkg::RST_ZERO;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            reg_rdata  <= fsa_pkg::RST_ZERO;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= read_mux;
            end
        end
    end

    // ------------------------------------------------------------------
    // per-channel protective shutdown detection
    // ------------------------------------------------------------------
    logic [3:0] chan_prot_shdn;

    genvar ch;
    generate
        for (ch = 0; ch < fsa_pkg::NUM_CH; ch++) begin : g_chan
            assign chan_prot_shdn[ch] =
                chan_state[ch*fsa_pkg::STATE_W +: fsa_pkg::STATE_W]
                == fsa_pkg::STATE_PROT_SHDN;
        end
    endgenerate

    // ------------------------------------------------------------------
    // source terms
    // ------------------------------------------------------------------
    logic supply_latched_any;
    logic supply_live_any;
    logic warn_next;
    logic [6:0] src_latched;
    logic [6:0] src_live;

    // power-on reset has no live form, so the live group leaves it out
    assign supply_latched_any = battery_undervoltage[0]
                              | battery_overvoltage[0]
                              | stage_supply_undervoltage[0]
                              | stage_supply_overvoltage[0]
                              | gate_supply_fault[0]
                              | logic_supply_reset_latched;
    assign supply_live_any    = battery_undervoltage[1]
                              | battery_overvoltage[1]
                              | stage_supply_undervoltage[1]
                              | stage_supply_overvoltage[1]
                              | gate_supply_fault[1];

    assign warn_next = (warn_conf_reg[fsa_pkg::WC_OVERTEMP_WARN]
                        & |overtemp_warn_latched)
                     | warn_other;

    always_comb begin
        src_latched = '0;
        src_latched[fsa_pkg::ML_PROT_SHUTDOWN] = |chan_prot_shdn;
        src_latched[fsa_pkg::ML_INVALID_CLOCK] = invalid_clock_latched;
        src_latched[fsa_pkg::ML_OVERHEAT] =
            |overheat_shutdown_latched;
        src_latched[fsa_pkg::ML_SUPPLY] = supply_latched_any;
        src_latched[fsa_pkg::ML_DC_OFFSET] = |dc_offset_latched;
        src_latched[fsa_pkg::ML_OVERCURRENT] = |overcurrent_latched;
        src_latched[fsa_pkg::ML_CURRENT_LIMIT] =
            |current_limit_latched;
    end

    // live warning drives the source so warning and fault move together
    always_comb begin
        src_live = '0;
        src_live[fsa_pkg::MV_WARN] = warn_next;
        src_live[fsa_pkg::MV_INVALID_CLOCK] = invalid_clock_live;
        src_live[fsa_pkg::MV_OVERHEAT] = |overheat_shutdown_live;
        src_live[fsa_pkg::MV_SUPPLY] = supply_live_any;
        src_live[fsa_pkg::MV_LOAD_DIAG] = ~&load_diag_done;
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            warn_active <= 1'b0;
        end else begin
            warn_active <= warn_next;
        end
    end

    // bit 7 of both masks and bits 2..1 of the live mask are masked off
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            fault_active <= 1'b0;
        end else begin
            fault_active <= |(src_latched & mask_latched_reg[6:0])
                          | |(src_live & mask_live_reg[6:0]);
        end
    end

endmodule : fsa_fault_aggregator

// ---- hw/fsa_pkg.sv ----
// constants shared by the fault signal aggregator
package fsa_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam int         ADDR_W              = 8;
    localparam int         DATA_W              = 8;
    localparam logic [7:0] ADDR_FOLDBACK_STAT  = 8'h1c;
    localparam logic [7:0] ADDR_MASK_LATCHED   = 8'h1d;
    localparam logic [7:0] ADDR_MASK_LIVE      = 8'h1e;
    localparam logic [7:0] ADDR_WARN_CONF      = 8'h1f;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_MASK_LATCHED    = 8'h17;
    localparam logic [7:0] RST_MASK_LIVE       = 8'h00;
    localparam logic [7:0] RST_WARN_CONF       = 8'h04;
    localparam logic [7:0] RST_ZERO            = 8'h00;

    // ------------------------------------------------------------------
    // fields of the latched-source mask
    // ------------------------------------------------------------------
    localparam int ML_PROT_SHUTDOWN = 6;
    localparam int ML_INVALID_CLOCK = 5;
    localparam int ML_OVERHEAT      = 4;
    localparam int ML_SUPPLY        = 3;
    localparam int ML_DC_OFFSET     = 2;
    localparam int ML_OVERCURRENT   = 1;
    localparam int ML_CURRENT_LIMIT = 0;

    // ------------------------------------------------------------------
    // fields of the live-source mask and warning enable
    // ------------------------------------------------------------------
    localparam int MV_WARN          = 6;
    localparam int MV_INVALID_CLOCK = 5;
    localparam int MV_OVERHEAT      = 4;
    localparam int MV_SUPPLY        = 3;
    localparam int MV_LOAD_DIAG     = 0;
    localparam int WC_OVERTEMP_WARN = 2;

    // ------------------------------------------------------------------
    // channel and flag geometry
    // ------------------------------------------------------------------
    localparam int         NUM_CH          = 4;
    localparam int         STATE_W         = 3;
    localparam logic [2:0] STATE_PROT_SHDN = 3'h5;
    localparam int         GAIN_W          = 5;
    localparam logic [4:0] GAIN_MAX_CODE   = 5'h18;

endpackage : fsa_pkg

// ---- verification/fsa_monitor.sv ----
// checker of the fault aggregator port behaviour
`timescale 1ns/1ns
module fsa_monitor (
    input wire logic        mclk, reset_n, reg_wr, reg_rd, reg_rvalid,
    input wire logic [7:0]  reg_addr, reg_wdata, reg_rdata,
    input wire logic [11:0] chan_state,
    input wire logic        invalid_clock_latched, invalid_clock_live,
    input wire logic [4:0]  overheat_shutdown_latched, overheat_shutdown_live,
    input wire logic [1:0]  battery_undervoltage, battery_overvoltage,
    input wire logic [1:0]  stage_supply_undervoltage,
    input wire logic [1:0]  stage_supply_overvoltage, gate_supply_fault,
    input wire logic        logic_supply_reset_latched, warn_other,
    input wire logic [3:0]  dc_offset_latched, overcurrent_latched,
    input wire logic [3:0]  current_limit_latched, load_diag_done,
    input wire logic [4:0]  overtemp_warn_latched, foldback_attenuation,
    input wire logic        warn_active, fault_active
);
    // ------------------------------------------------------------
    // shadow of the mask and warning enable registers, kept from the write strobes
    // ------------------------------------------------------------
    logic [7:0] ml_reg;
    logic [7:0] mv_reg;
    logic       wc_reg;
    logic       prot;
    logic       sup_l;
    logic       sup_v;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            ml_reg <= 8'h17;
            mv_reg <= 8'h00;
            wc_reg <= 1'b1;
        end else if (reg_wr) begin
            if (reg_addr == 8'h1d) ml_reg <= reg_wdata;
            if (reg_addr == 8'h1e) mv_reg <= reg_wdata;
            if (reg_addr == 8'h1f) wc_reg <= reg_wdata[2];
        end
    end

    assign prot = chan_state[2:0] == 3'h5 || chan_state[5:3] == 3'h5
               || chan_state[8:6] == 3'h5 || chan_state[11:9] == 3'h5;
    assign sup_l = battery_undervoltage[0] | battery_overvoltage[0]
                 | stage_supply_undervoltage[0] | stage_supply_overvoltage[0]
                 | gate_supply_fault[0] | logic_supply_reset_latched;
    // power-on reset has no live copy, so it stays out of this group
    assign sup_v = battery_undervoltage[1] | battery_overvoltage[1]
                 | stage_supply_undervoltage[1] | stage_supply_overvoltage[1]
                 | gate_supply_fault[1];

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    a_gain_read: assert property (reg_rd && reg_addr == 8'h1c
        && $past(foldback_attenuation) <= 5'h18
        |=> reg_rdata == {3'h0, $past(foldback_attenuation, 2)})
        else $error("foldback status read wrong");
    a_prot_shutdown: assert property (ml_reg[6] && prot |=> fault_active)
        else $error("fault missing on protective shutdown");
    a_latched_flags: assert property ((ml_reg[5] && invalid_clock_latched
        || ml_reg[4] && |overheat_shutdown_latched || ml_reg[3] && sup_l)
        |=> fault_active) else $error("fault missing on stored flag");
    a_chan_faults: assert property ((ml_reg[2] && |dc_offset_latched
        || ml_reg[1] && |overcurrent_latched
        || ml_reg[0] && |current_limit_latched) |=> fault_active)
        else $error("fault missing on channel flag");
    a_live_sources: assert property ((mv_reg[5] && invalid_clock_live
        || mv_reg[4] && |overheat_shutdown_live || mv_reg[3] && sup_v
        || mv_reg[0] && !(&load_diag_done)) |=> fault_active)
        else $error("fault missing on live flag");
    a_warn_fault: assert property ($past(mv_reg[6]) && warn_active
        |-> fault_active) else $error("fault not following warning");
    a_warn_default: assert property (wc_reg && |overtemp_warn_latched
        |=> warn_active) else $error("warning missing on stored warn");
    a_fault_clear: assert property (!(ml_reg[6] && prot
        || ml_reg[5] && invalid_clock_latched || sup_l || sup_v
        || |overheat_shutdown_latched || |overheat_shutdown_live
        || |dc_offset_latched || |overcurrent_latched
        || |current_limit_latched || invalid_clock_live
        || !(&load_diag_done) || mv_reg[6])
        |=> !fault_active) else $error("fault stuck with no source");
    a_mask_readback: assert property (reg_rd && reg_addr == 8'h1d
        |=> reg_rvalid && reg_rdata == $past(ml_reg))
        else $error("latched mask read wrong");

    c_fault: cover property (fault_active && !warn_active);
    c_warn_fault: cover property (warn_active && fault_active);
    c_read: cover property (reg_rvalid);
endmodule : fsa_monitor

bind fsa_fault_aggregator fsa_monitor u_fsa_monitor (.*);

// ---- verification/fsa_host_model.sv ----
// host side model: register access with released lines scrambled
`timescale 1ns/1ns
module fsa_host_model (
    input  wire logic       mclk,        // core clock
    output logic      [7:0] reg_addr,    // offset
    output logic      [7:0] reg_wdata,   // write data
    output logic            reg_wr,      // write strobe
    output logic            reg_rd,      // read strobe
    input  wire logic [7:0] reg_rdata,   // read data
    input  wire logic       reg_rvalid   // read valid
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // idle lines show the inverse so a stale value is never reused
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge mclk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d,
                      output logic v);
        @(negedge mclk);
        reg_addr = a;
        reg_rd = 1'b1;
        // the answer stands for one cycle after the strobe edge
        @(negedge mclk);
        d = reg_rdata;
        v = reg_rvalid;
        reg_rd = 1'b0;
        reg_addr = ~a;
    endtask : rd
endmodule : fsa_host_model

// ---- verification/tb.sv ----
// self-checking bench for the fault aggregator
`timescale 1ns/1ns
module tb;
    logic mclk = 1'b0, reset_n = 1'b0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rdv;
    logic reg_wr, reg_rd, reg_rvalid, warn_active, fault_active, vld;
    logic [11:0] chan_state = 12'h000;
    logic invalid_clock_latched = 0, invalid_clock_live = 0;
    logic logic_supply_reset_latched = 0, warn_other = 0;
    logic [4:0] overheat_shutdown_latched = 0, overheat_shutdown_live = 0;
    logic [4:0] overtemp_warn_latched = 0, foldback_attenuation = 0;
    logic [1:0] battery_undervoltage = 0, battery_overvoltage = 0;
    logic [1:0] stage_supply_undervoltage = 0, stage_supply_overvoltage = 0;
    logic [1:0] gate_supply_fault = 0;
    logic [3:0] dc_offset_latched = 0, overcurrent_latched = 0;
    logic [3:0] current_limit_latched = 0, load_diag_done = 4'hf;
    logic [7:0] sm [0:12] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20,
        8'h40, 8'h20, 8'h10, 8'h08, 8'h01, 8'h40, 8'h08};
    logic [4:0] gv [0:3] = '{5'h00, 5'h01, 5'h17, 5'h18};
    int mismatches = 0, checked = 0, cycles = 0;

    always #10 mclk = ~mclk;
    fsa_fault_aggregator u_fsa_fault_aggregator (.*);
    fsa_host_model u_fsa_host_model (.mclk(mclk), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

    task automatic stop_test();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test

    task automatic chk(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        u_fsa_host_model.rd(a, rdv, vld);
        chk("read valid", {7'h00, vld}, 8'h01);
        chk($sformatf("reg %h", a), rdv, exp);
    endtask : rchk

    // one representative input per fault source, index matches sm
    task automatic src(input int k, input logic v);
        case (k)
            0: current_limit_latched[2] = v;
            1: overcurrent_latched[1] = v;
            2: dc_offset_latched[3] = v;
            3: logic_supply_reset_latched = v;
            4: overheat_shutdown_latched[4] = v;
            5: invalid_clock_latched = v;
            6: chan_state[11:9] = v ? 3'h5 : 3'h4;
            7: invalid_clock_live = v;
            8: overheat_shutdown_live[0] = v;
            9: gate_supply_fault[1] = v;
            10: load_diag_done[1] = !v;
            11: overtemp_warn_latched[2] = v;
            default: logic_supply_reset_latched = v;
        endcase
    endtask : src

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            stop_test();
        end
    end

    initial begin
        repeat (4) @(negedge mclk);
        reset_n = 1'b1;
        rchk(8'h1d, 8'h17);
        rchk(8'h1e, 8'h00);
        rchk(8'h1f, 8'h04);
        rchk(8'h30, 8'h00);
        $display("test reset values done");
        foreach (gv[i]) begin
            foldback_attenuation = gv[i];
            rchk(8'h1c, {3'h0, gv[i]});
        end
        u_fsa_host_model.wr(8'h1c, 8'hff);
        rchk(8'h1c, 8'h18);
        foldback_attenuation = 5'h1f;
        rchk(8'h1c, 8'h18);
        u_fsa_host_model.wr(8'h1e, 8'h86);
        rchk(8'h1e, 8'h86);
        chk("fault idle", {7'h00, fault_active}, 8'h00);
        u_fsa_host_model.wr(8'h1e, 8'h00);
        u_fsa_host_model.wr(8'h1d, 8'h00);
        $display("test register access done");
        for (int k = 0; k < 13; k++) begin
            u_fsa_host_model.wr(k < 7 ? 8'h1d : 8'h1e, sm[k]);
            src(k, 1'b1);
            repeat (2) @(negedge mclk);
            chk("fault on", {7'h00, fault_active}, k != 12);
            src(k, 1'b0);
            repeat (2) @(negedge mclk);
            chk("fault off", {7'h00, fault_active}, 8'h00);
            u_fsa_host_model.wr(k < 7 ? 8'h1d : 8'h1e, 8'h00);
        end
        $display("test fault sources done");
        src(11, 1'b1);
        repeat (2) @(negedge mclk);
        chk("warn on", {7'h00, warn_active}, 8'h01);
        u_fsa_host_model.wr(8'h1f, 8'h00);
        @(negedge mclk);
        chk("warn off", {7'h00, warn_active}, 8'h00);
        warn_other = 1'b1;
        repeat (2) @(negedge mclk);
        chk("warn other", {7'h00, warn_active}, 8'h01);
        $display("test warning enable done");
        stop_test();
    end
endmodule : tb
